// ### hsp_host_model.sv
// Host terminal model: frames bytes onto the receive line, decodes the transmit line.
// Assumes the bench sets bit time, length and parity before any traffic.
`timescale 1ns/1ps
module hsp_host_model (
    input  wire logic i_clk,
    input  wire logic i_txd,
    input  wire logic i_rts,
    input  wire logic i_dtr,
    output logic      o_rxd,
    output logic      o_cts,
    output logic      o_dsr
);
    int         bitc  = 32;
    int         nbits = 8;
    int         par   = 0;
    int         nrx   = 0;
    int         lowc  = 0;
    int         swid  = 0;
    logic       ok    = 1'b1;
    logic [7:0] last  = 8'h00;

    initial begin
        o_rxd = 1'b1;
        o_cts = 1'b1;
        o_dsr = 1'b1;
    end

    // --------------------------------------------------------------
    // Decode
    // --------------------------------------------------------------
    // Length of the last low run; bytes sent through tx_frame end on a lone low bit, tick-aligned
    // unlike the start bit, whose first tick falls anywhere in the divider period
    always @(posedge i_clk) begin
        if (i_txd === 1'b0) begin
            lowc++;
        end else begin
            if (lowc > 0) swid = lowc;
            lowc = 0;
        end
    end

    initial begin : rx_loop
        logic [7:0] d;
        logic       p;
        forever begin
            @(posedge i_clk iff i_txd === 1'b0);
            d = 8'h00;
            repeat (bitc / 2) @(posedge i_clk);
            ok = (i_txd === 1'b0);
            for (int k = 0; k < nbits; k++) begin
                repeat (bitc) @(posedge i_clk);
                d[k] = i_txd;
            end
            if (par != 0) begin
                repeat (bitc) @(posedge i_clk);
                p = (^d) ^ (par == 1);
                ok &= (i_txd === p);
            end
            repeat (bitc) @(posedge i_clk);
            ok &= (i_txd === 1'b1);
            last = d;
            nrx++;
        end
    end

    // --------------------------------------------------------------
    // Send
    // --------------------------------------------------------------
    // 8N1 only; every scenario that sends runs that format
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int k = 0; k < 10; k++) begin
            o_rxd <= f[k];
            repeat (bitc) @(posedge i_clk);
        end
    endtask : send
endmodule : hsp_host_model

// ### hsp_host_serial_port.sv
// Host serial port: full-duplex asynchronous port with AHB-Lite register access.
// Assumes one clock, synchronous reset, zero-wait AHB-Lite master, RS-232 pins
// already translated to logic levels (1 = marking / ON).
//
// Contract
// - Receive and transmit run together at one rate chosen from twelve, 1200 baud by default.
// - A frame holds 7 or 8 data bits (8 by default), optional odd or even parity (none by default), one stop bit.
// - RTS/CTS plus DSR/DTR handshaking is selectable, off by default, and when off the modem inputs never gate sending.
// - XON/XOFF flow control is selectable, off by default, and pauses sending after XOFF until XON.
// - Rate, parity, length and both handshake enables are writable by the setup menu and by host commands.
// - With battery backup present the settings in force before power loss survive instead of the defaults.
//
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module hsp_host_serial_port
    import hsp_pkg::*;
#(
    parameter int CLK_HZ = HSP_CLK_HZ,
    parameter int DIV_W  = 18
) (
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic        i_hready,
    input  wire logic [31:0] i_hwdata,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    input  wire logic        i_rxd,
    output logic             o_txd,
    input  wire logic        i_cts,
    input  wire logic        i_dsr,
    output logic             o_rts,
    output logic             o_dtr,
    input  wire logic        i_batt_ok
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]       rxd_s;
        logic [1:0]       cts_s;
        logic [1:0]       dsr_s;
        logic [1:0]       batt_s;
        logic [3:0]       baud;
        logic             len8;
        hsp_par_e         par;
        logic             hw_en;
        logic             sw_en;
        logic             ph_wr;
        logic [3:0]       ph_addr;
        logic [31:0]      rdata;
        logic [DIV_W-1:0] div_cnt;
        logic             tick;
        hsp_tx_e          tx_st;
        logic [3:0]       tx_ph;
        logic [3:0]       tx_n;
        logic [9:0]       tx_sh;
        logic             txd;
        logic             tx_full;
        logic [7:0]       tx_buf;
        hsp_rx_e          rx_st;
        logic [3:0]       rx_ph;
        logic [3:0]       rx_n;
        logic [9:0]       rx_sh;
        logic [7:0]       rx_data;
        logic             rx_valid;
        logic             par_err;
        logic             frm_err;
        logic             ovr;
        logic             xoff;
    } hsp_state_s;

    hsp_state_s s;
    hsp_state_s next_s;

    // ------------------------------------------------------------------
    // Rate table
    // ------------------------------------------------------------------
    function automatic logic [DIV_W-1:0] div_of(input int unsigned rate);
        return DIV_W'(CLK_HZ / (rate * HSP_OVS) - 1);
    endfunction : div_of

    logic [DIV_W-1:0] div_tab [HSP_NRATES];
    logic [DIV_W-1:0] div_lim;

    // Constant per entry, so no divider is built
    for (genvar gi = 0; gi < HSP_NRATES; gi++) begin : g_rate
        assign div_tab[gi] = div_of(HSP_RATES[gi]);
    end

    assign div_lim = div_tab[s.baud];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic       a_phase;
    logic       can_send;
    logic [3:0] nbits;
    logic [7:0] rx_word;
    logic [9:0] rx_full;
    logic       par_calc;

    always_comb begin
        next_s   = s;
        a_phase  = i_hsel & i_htrans[1] & i_hready;
        nbits    = 4'(7 + int'(s.len8) + int'(s.par != HSP_PAR_NONE) + 1);
        can_send = (!s.hw_en || (s.cts_s[1] && s.dsr_s[1])) && !(s.sw_en && s.xoff);
        rx_full  = s.rx_sh;
        rx_full[s.rx_n] = s.rxd_s[1];
        rx_word  = s.len8 ? rx_full[7:0] : {1'b0, rx_full[6:0]};
        par_calc = ^rx_word ^ (s.par == HSP_PAR_ODD);

        // Pin synchronisers
        next_s.rxd_s  = {s.rxd_s[0], i_rxd};
        next_s.cts_s  = {s.cts_s[0], i_cts};
        next_s.dsr_s  = {s.dsr_s[0], i_dsr};
        next_s.batt_s = {s.batt_s[0], i_batt_ok};

        // Oversampling tick, sixteen per bit
        if (s.div_cnt == div_lim) begin
            next_s.div_cnt = '0;
            next_s.tick    = 1'b1;
        end else begin
            next_s.div_cnt = s.div_cnt + 1'b1;
            next_s.tick    = 1'b0;
        end

        // Address phase: read data is latched here, zero wait states
        next_s.ph_wr   = a_phase & i_hwrite;
        next_s.ph_addr = i_haddr[3:0];
        if (a_phase && !i_hwrite) begin
            next_s.rdata = '0;
            unique case (i_haddr[3:0])
                HSP_OFS_CTRL: begin
                    next_s.rdata[HSP_CTL_BAUD +: 4] = s.baud;
                    next_s.rdata[HSP_CTL_LEN8]      = s.len8;
                    next_s.rdata[HSP_CTL_PAR +: 2]  = s.par;
                    next_s.rdata[HSP_CTL_HW]        = s.hw_en;
                    next_s.rdata[HSP_CTL_SW]        = s.sw_en;
                end
                HSP_OFS_STAT: begin
                    next_s.rdata[HSP_ST_BUSY] = (s.tx_st != HSP_TX_IDLE) || s.tx_full;
                    next_s.rdata[HSP_ST_RXV]  = s.rx_valid;
                    next_s.rdata[HSP_ST_XOFF] = s.xoff;
                    next_s.rdata[HSP_ST_PERR] = s.par_err;
                    next_s.rdata[HSP_ST_FERR] = s.frm_err;
                    next_s.rdata[HSP_ST_OVR]  = s.ovr;
                    next_s.rdata[HSP_ST_CTS]  = s.cts_s[1];
                    next_s.rdata[HSP_ST_DSR]  = s.dsr_s[1];
                    next_s.rdata[HSP_ST_TXF]  = s.tx_full;
                end
                HSP_OFS_RXD: begin
                    next_s.rdata[7:0] = s.rx_data;
                    next_s.rx_valid   = 1'b0;
                    next_s.par_err    = 1'b0;
                    next_s.frm_err    = 1'b0;
                    next_s.ovr        = 1'b0;
                end
                default: next_s.rdata = '0;
            endcase
        end

        // Data phase writes
        if (s.ph_wr) begin
            if (s.ph_addr == HSP_OFS_CTRL) begin
                if (i_hwdata[HSP_CTL_BAUD +: 4] <= HSP_BAUD_MAX) begin
                    next_s.baud    = i_hwdata[HSP_CTL_BAUD +: 4];
                    next_s.div_cnt = '0;
                end
                next_s.len8  = i_hwdata[HSP_CTL_LEN8];
                if (i_hwdata[HSP_CTL_PAR +: 2] != 2'h3) begin
                    next_s.par = hsp_par_e'(i_hwdata[HSP_CTL_PAR +: 2]);
                end
                next_s.hw_en = i_hwdata[HSP_CTL_HW];
                next_s.sw_en = i_hwdata[HSP_CTL_SW];
                if (!i_hwdata[HSP_CTL_SW]) begin
                    next_s.xoff = 1'b0;
                end
            end else if (s.ph_addr == HSP_OFS_TXD && !s.tx_full) begin
                next_s.tx_buf  = i_hwdata[7:0];
                next_s.tx_full = 1'b1;
            end
        end

        // Transmitter
        unique case (s.tx_st)
            HSP_TX_IDLE: begin
                next_s.txd = 1'b1;
                if (s.tx_full && can_send) begin
                    next_s.tx_full = 1'b0;
                    next_s.tx_st   = HSP_TX_START;
                    next_s.txd     = 1'b0;
                    next_s.tx_ph   = '0;
                    next_s.tx_n    = nbits;
                    next_s.tx_sh   = '1;
                    if (s.len8) begin
                        next_s.tx_sh[7:0] = s.tx_buf;
                    end else begin
                        next_s.tx_sh[6:0] = s.tx_buf[6:0];
                    end
                    if (s.par != HSP_PAR_NONE) begin
                        next_s.tx_sh[s.len8 ? 8 : 7] =
                            ^(s.len8 ? s.tx_buf : {1'b0, s.tx_buf[6:0]}) ^ (s.par == HSP_PAR_ODD);
                    end
                end
            end
            HSP_TX_START, HSP_TX_BITS: begin
                if (s.tick) begin
                    next_s.tx_ph = s.tx_ph + 1'b1;
                    if (s.tx_ph == HSP_PH_LAST) begin
                        if (s.tx_n == '0) begin
                            next_s.tx_st = HSP_TX_IDLE;
                        end else begin
                            next_s.tx_st = HSP_TX_BITS;
                            next_s.txd   = s.tx_sh[0];
                            next_s.tx_sh = {1'b1, s.tx_sh[9:1]};
                            next_s.tx_n  = s.tx_n - 1'b1;
                        end
                    end
                end
            end
        endcase

        // Receiver; a new frame's flags win over a same-cycle read clear
        unique case (s.rx_st)
            HSP_RX_IDLE: begin
                if (s.tick && !s.rxd_s[1]) begin
                    next_s.rx_st = HSP_RX_START;
                    next_s.rx_ph = '0;
                end
            end
            HSP_RX_START: begin
                if (s.tick) begin
                    next_s.rx_ph = s.rx_ph + 1'b1;
                    if (s.rx_ph == HSP_PH_MID) begin
                        // Glitch shorter than half a bit is dropped
                        next_s.rx_st = s.rxd_s[1] ? HSP_RX_IDLE : HSP_RX_BITS;
                        next_s.rx_ph = '0;
                        next_s.rx_n  = '0;
                    end
                end
            end
            HSP_RX_BITS: begin
                if (s.tick) begin
                    next_s.rx_ph = s.rx_ph + 1'b1;
                    if (s.rx_ph == HSP_PH_LAST) begin
                        next_s.rx_sh = rx_full;
                        next_s.rx_n  = s.rx_n + 1'b1;
                        if (s.rx_n == nbits - 1'b1) begin
                            next_s.rx_st = HSP_RX_IDLE;
                            if (s.sw_en && rx_word == HSP_XOFF) begin
                                next_s.xoff = 1'b1;
                            end else if (s.sw_en && rx_word == HSP_XON) begin
                                next_s.xoff = 1'b0;
                            end else if (s.rx_valid && next_s.rx_valid) begin
                                next_s.ovr = 1'b1;
                            end else begin
                                next_s.rx_data  = rx_word;
                                next_s.rx_valid = 1'b1;
                                next_s.frm_err  = next_s.frm_err | !s.rxd_s[1];
                                if (s.par != HSP_PAR_NONE && par_calc != rx_full[s.len8 ? 8 : 7]) begin
                                    next_s.par_err = 1'b1;
                                end
                            end
                        end
                    end
                end
            end
        endcase

        // Settings survive reset only while the backup supply is good
        if (i_srst) begin
            next_s = '0;
            next_s.rxd_s  = {s.rxd_s[0], i_rxd};
            next_s.cts_s  = {s.cts_s[0], i_cts};
            next_s.dsr_s  = {s.dsr_s[0], i_dsr};
            next_s.batt_s = {s.batt_s[0], i_batt_ok};
            next_s.txd    = 1'b1;
            if (s.batt_s[1]) begin
                next_s.baud  = s.baud;
                next_s.len8  = s.len8;
                next_s.par   = s.par;
                next_s.hw_en = s.hw_en;
                next_s.sw_en = s.sw_en;
            end else begin
                next_s.baud  = HSP_BAUD_DEF;
                next_s.len8  = 1'b1;
                next_s.par   = HSP_PAR_NONE;
                next_s.hw_en = 1'b0;
                next_s.sw_en = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        s <= next_s;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_hrdata    = s.rdata;
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;
    assign o_txd       = s.txd;
    assign o_rts       = s.hw_en ? !s.rx_valid : 1'b1;
    assign o_dtr       = 1'b1;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    a_idle_marking: assert property (s.tx_st == HSP_TX_IDLE && !$past(s.tx_st == HSP_TX_IDLE) |-> o_txd)
        else $error("line not marking after frame");
    a_start_bit: assert property ($rose(s.tx_st == HSP_TX_START) |-> !o_txd ##1 !o_txd)
        else $error("start bit not spacing");
    a_hw_gate: assert property (s.hw_en && !(s.cts_s[1] && s.dsr_s[1]) && s.tx_st == HSP_TX_IDLE
                                |=> s.tx_st == HSP_TX_IDLE)
        else $error("sent while modem inputs off");
    a_hw_off_rts: assert property (!s.hw_en |-> o_rts)
        else $error("rts dropped with handshake off");
    a_xoff_pause: assert property (s.sw_en && s.xoff && s.tx_st == HSP_TX_IDLE |=> s.tx_st == HSP_TX_IDLE)
        else $error("sent while paused by xoff");
    a_default_cfg: assert property ($fell(i_srst) && !$past(s.batt_s[1])
                                    |-> s.baud == HSP_BAUD_DEF && s.len8 && s.par == HSP_PAR_NONE
                                        && !s.hw_en && !s.sw_en)
        else $error("defaults not loaded");
    a_cfg_kept: assert property ($fell(i_srst) && $past(s.batt_s[1])
                                 |-> s.baud == $past(s.baud) && s.len8 == $past(s.len8))
        else $error("settings lost over backed reset");
    a_ctrl_write: assert property (s.ph_wr && s.ph_addr == HSP_OFS_CTRL
                                   |=> s.sw_en == $past(i_hwdata[HSP_CTL_SW]) && s.len8 == $past(i_hwdata[HSP_CTL_LEN8]))
        else $error("control write not applied");
    a_frame_len: assert property ($rose(s.tx_st == HSP_TX_START) |-> s.tx_n == 4'(8 + int'(s.len8)
                                  + int'(s.par != HSP_PAR_NONE)))
        else $error("frame length wrong");

    c_tx_frame: cover property ($fell(s.tx_st == HSP_TX_IDLE) ##[1:1000] s.tx_st == HSP_TX_IDLE);
    c_rx_byte: cover property ($rose(s.rx_valid));
    c_xoff: cover property ($rose(s.xoff));
    c_par_err: cover property ($rose(s.par_err));

endmodule : hsp_host_serial_port

// ### hsp_host_serial_port_test.sv
// Self-checking bench: AHB-Lite register tasks, serial traffic through the host model.
// Assumes the port is the only bus slave and a slowed clock-rate parameter.
`timescale 1ns/1ps
module hsp_host_serial_port_test
    import hsp_pkg::*;
;
    localparam int CLK_HZ = 1_600_000;
    localparam int LIMIT  = 60000;
    logic        i_clk      = 1'b0;
    logic        i_srst     = 1'b1;
    logic        hsel       = 1'b0;
    logic [31:0] haddr      = 32'h0;
    logic [1:0]  htrans     = 2'h0;
    logic        hwrite     = 1'b0;
    logic [31:0] hwdata     = 32'h0;
    logic        batt       = 1'b0;
    logic [31:0] hrdata;
    logic        hready, hresp, txd, rxd, cts, dsr, rts, dtr;
    int          num_errors = 0;
    int          n_tests    = 0;
    int          cyc        = 0;
    int          n0;
    logic [31:0] rd;

    hsp_host_serial_port #(.CLK_HZ(CLK_HZ)) i_dut (
        .i_clk(i_clk), .i_srst(i_srst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hready(hready), .i_hwdata(hwdata), .o_hrdata(hrdata),
        .o_hreadyout(hready), .o_hresp(hresp), .i_rxd(rxd), .o_txd(txd), .i_cts(cts), .i_dsr(dsr),
        .o_rts(rts), .o_dtr(dtr), .i_batt_ok(batt));
    hsp_host_model i_host (.i_clk(i_clk), .i_txd(txd), .i_rts(rts), .i_dtr(dtr),
        .o_rxd(rxd), .o_cts(cts), .o_dsr(dsr));

    initial begin
        forever #2.5 i_clk = ~i_clk;
    end

    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    function automatic int bt(input int r);
        return 16 * (CLK_HZ / (r * 16));
    endfunction : bt

    task automatic ahb(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {28'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge i_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge i_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic cfg(input logic [31:0] c, input int nb, input int pr);
        ahb(1'b1, HSP_OFS_CTRL, c);
        ahb(1'b0, HSP_OFS_CTRL, 32'h0);
        chk("ctrl readback", c, rd);
        i_host.bitc  = bt(HSP_RATES[11]);
        i_host.nbits = nb;
        i_host.par   = pr;
    endtask : cfg

    task automatic tx_frame(input logic [7:0] b);
        n0 = i_host.nrx;
        ahb(1'b1, HSP_OFS_TXD, {24'h0, b});
        while (i_host.nrx == n0) @(posedge i_clk);
        chk("tx byte", {24'h0, b}, {24'h0, i_host.last});
        chk("frame ok", 32'h1, {31'h0, i_host.ok});
        chk("lone bit width", i_host.bitc, i_host.swid);
    endtask : tx_frame

    task automatic do_reset;
        i_srst <= 1'b1;
        repeat (5) @(posedge i_clk);
        i_srst <= 1'b0;
        @(posedge i_clk);
    endtask : do_reset

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    // Hang guard, well above the slow default-rate frame
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            num_errors++;
            close_out();
        end
    end

    // --------------------------------------------------------------
    // Tests
    // --------------------------------------------------------------
    initial begin
        repeat (5) @(posedge i_clk);
        i_srst <= 1'b0;
        @(posedge i_clk);
        ahb(1'b0, HSP_OFS_CTRL, 32'h0);
        chk("ctrl default", 32'h15, rd);
        i_host.bitc = bt(HSP_RATES[5]);
        i_host.o_cts <= 1'b0;
        i_host.o_dsr <= 1'b0;
        tx_frame(8'hbf);
        $display("test defaults done");
        cfg(32'h5b, 8, 2);
        tx_frame(8'hb7);
        cfg(32'h2b, 7, 1);
        tx_frame(8'h6d);
        $display("test formats done");
        cfg(32'h9b, 8, 0);
        i_host.o_dsr <= 1'b1;
        n0 = i_host.nrx;
        ahb(1'b1, HSP_OFS_TXD, 32'h35);
        repeat (8 * i_host.bitc) @(posedge i_clk);
        chk("held by cts", n0, i_host.nrx);
        i_host.o_cts <= 1'b1;
        while (i_host.nrx == n0) @(posedge i_clk);
        chk("tx after cts", 32'h35, {24'h0, i_host.last});
        i_host.send(8'ha5);
        repeat (40) @(posedge i_clk);
        chk("rts full", 32'h0, {31'h0, rts});
        chk("dtr on", 32'h1, {31'h0, dtr});
        i_host.send(8'h5a);
        repeat (40) @(posedge i_clk);
        ahb(1'b0, HSP_OFS_STAT, 32'h0);
        chk("rx valid", 32'h1, {31'h0, rd[HSP_ST_RXV]});
        chk("overrun", 32'h1, {31'h0, rd[HSP_ST_OVR]});
        chk("hresp okay", 32'h0, {31'h0, hresp});
        ahb(1'b0, HSP_OFS_RXD, 32'h0);
        chk("rx byte", 32'ha5, {24'h0, rd[7:0]});
        chk("rts free", 32'h1, {31'h0, rts});
        $display("test handshake done");
        cfg(32'h11b, 8, 0);
        i_host.send(HSP_XOFF);
        repeat (40) @(posedge i_clk);
        ahb(1'b0, HSP_OFS_STAT, 32'h0);
        chk("paused", 32'h1, {31'h0, rd[HSP_ST_XOFF]});
        n0 = i_host.nrx;
        ahb(1'b1, HSP_OFS_TXD, 32'h27);
        repeat (8 * i_host.bitc) @(posedge i_clk);
        chk("held by xoff", n0, i_host.nrx);
        i_host.send(HSP_XON);
        while (i_host.nrx == n0) @(posedge i_clk);
        chk("tx after xon", 32'h27, {24'h0, i_host.last});
        $display("test xon xoff done");
        batt <= 1'b1;
        // Battery level must clear its synchroniser before reset samples it
        repeat (3) @(posedge i_clk);
        do_reset();
        ahb(1'b0, HSP_OFS_CTRL, 32'h0);
        chk("ctrl kept", 32'h11b, rd);
        batt <= 1'b0;
        do_reset();
        ahb(1'b0, HSP_OFS_CTRL, 32'h0);
        chk("ctrl fresh", 32'h15, rd);
        $display("test battery done");
        close_out();
    end
endmodule : hsp_host_serial_port_test

// ### hsp_pkg.sv
// Constants and types for the host serial port: register map, fields, rates.
// Assumes a single system clock; every count derives from the module's clock rate.
package hsp_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          HSP_CLK_HZ   = 200_000_000;
    localparam int          HSP_OVS      = 16;
    localparam logic [3:0]  HSP_PH_LAST  = 4'hf;
    localparam logic [3:0]  HSP_PH_MID   = 4'h7;
    localparam int          HSP_NRATES   = 12;
    localparam int unsigned HSP_RATES [HSP_NRATES] = '{75, 110, 150, 300, 600, 1200,
                                                       2000, 2400, 4800, 9600, 19200, 38400};
    localparam logic [3:0]  HSP_BAUD_DEF = 4'h5;
    localparam logic [3:0]  HSP_BAUD_MAX = 4'hb;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [3:0]  HSP_OFS_CTRL = 4'h0;
    localparam logic [3:0]  HSP_OFS_STAT = 4'h4;
    localparam logic [3:0]  HSP_OFS_TXD  = 4'h8;
    localparam logic [3:0]  HSP_OFS_RXD  = 4'hc;

    localparam int HSP_CTL_BAUD = 0;
    localparam int HSP_CTL_LEN8 = 4;
    localparam int HSP_CTL_PAR  = 5;
    localparam int HSP_CTL_HW   = 7;
    localparam int HSP_CTL_SW   = 8;

    localparam int HSP_ST_BUSY  = 0;
    localparam int HSP_ST_RXV   = 1;
    localparam int HSP_ST_XOFF  = 2;
    localparam int HSP_ST_PERR  = 3;
    localparam int HSP_ST_FERR  = 4;
    localparam int HSP_ST_OVR   = 5;
    localparam int HSP_ST_CTS   = 6;
    localparam int HSP_ST_DSR   = 7;
    localparam int HSP_ST_TXF   = 8;

    localparam logic [7:0]  HSP_XON      = 8'h11;
    localparam logic [7:0]  HSP_XOFF     = 8'h13;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {HSP_PAR_NONE, HSP_PAR_ODD, HSP_PAR_EVEN} hsp_par_e;
    typedef enum logic [1:0] {HSP_TX_IDLE, HSP_TX_START, HSP_TX_BITS} hsp_tx_e;
    typedef enum logic [1:0] {HSP_RX_IDLE, HSP_RX_START, HSP_RX_BITS} hsp_rx_e;

endpackage : hsp_pkg
